/* File: design/hfr_byte_fifo.sv */
// Synchronous first-in first-out store with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset; DEPTH need not be a power of two.
`default_nettype none

module hfr_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Both sides of the store.
  hfr_fifo_if.store q
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];       // Word storage.
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [PW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [LW-1:0] count_reg, count_next;
  logic push, pop;

  // Advance a pointer, wrapping after the last slot.
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : bump

  assign q.in_ready = (count_reg != LW'(DEPTH));
  assign q.out_valid = (count_reg != '0);
  assign q.out_data = mem[rd_ptr_reg];
  assign q.level = count_reg;
  assign push = q.in_valid & q.in_ready;
  assign pop = q.out_ready & q.out_valid;

  // ---------------------------------------------------------------------------
  // Next pointers and fill count.
  // ---------------------------------------------------------------------------
  always_comb begin
    wr_ptr_next = push ? bump(wr_ptr_reg) : wr_ptr_reg;
    rd_ptr_next = pop ? bump(rd_ptr_reg) : rd_ptr_reg;
    count_next = count_reg;
    if (push && !pop) begin
      count_next = LW'(count_reg + 1'b1);
    end else if (pop && !push) begin
      count_next = LW'(count_reg - 1'b1);
    end
  end

  // Register the pointers; storage itself is not reset, only its bookkeeping.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // Write the storage array.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= q.in_data;
    end
  end
endmodule : hfr_byte_fifo

`default_nettype wire

/* File: design/hfr_consts.svh */
// Constants for the packet FIFO and receive routing block: offsets, field positions, reset values, depths.
// Assumes it is included by bare name from package and design files that need these numbers.
`ifndef HFR_CONSTS_SVH
`define HFR_CONSTS_SVH

// -----------------------------------------------------------------------------
// Register offsets on the parallel control port.
// -----------------------------------------------------------------------------
`define HFR_OFS_RX_PACKET_BYTE_FIFO 8'hB4
`define HFR_OFS_TX_FIFO_CONDITION 8'hB6
`define HFR_OFS_TX_PACKET_BYTE_FIFO 8'hB7
`define HFR_OFS_RX_ROUTING_SELECT 8'hB8
`define HFR_OFS_RX_TIMESLOT_BIT_SUPPRESS 8'hB9

// -----------------------------------------------------------------------------
// Field positions.
// -----------------------------------------------------------------------------
`define HFR_TXC_VACANT_BIT 2
`define HFR_TXC_PACKED_BIT 1
`define HFR_TXC_UNDERFLOW_BIT 0
`define HFR_ROUTE_SOURCE_BIT 7
`define HFR_ROUTE_SA_OR_SLOT_BIT 6
`define HFR_ROUTE_MODE_BIT 5
`define HFR_ROUTE_SLOT_MSB 4
`define HFR_ROUTE_SLOT_LSB 0

// -----------------------------------------------------------------------------
// Reset values and sizes.
// -----------------------------------------------------------------------------
`define HFR_ROUTE_RESET 8'h00
`define HFR_SUPPRESS_RESET 8'h00
`define HFR_READ_IDLE 8'h00
`define HFR_FIFO_DEPTH 64

`endif

/* File: design/hfr_fifo_if.sv */
// Interface that joins a byte FIFO to the logic that fills and drains it.
// Assumes both ends run on the same clock.
`default_nettype none

interface hfr_fifo_if #(
  parameter int WIDTH = 8,
  parameter int LW = 7
);
  logic [WIDTH-1:0] in_data;  // Word offered by the filling side.
  logic in_valid;             // Filling side offers a word.
  logic in_ready;             // FIFO can take a word.
  logic [WIDTH-1:0] out_data; // Oldest stored word.
  logic out_valid;            // FIFO holds at least one word.
  logic out_ready;            // Draining side takes the oldest word.
  logic [LW-1:0] level;       // Number of words held.

  // The FIFO's own view.
  modport store (
    input in_data, in_valid, out_ready,
    output in_ready, out_data, out_valid, level
  );
  // The view of the logic around it.
  modport user (
    output in_data, in_valid, out_ready,
    input in_ready, out_data, out_valid, level
  );
endinterface : hfr_fifo_if

`default_nettype wire

/* File: design/hfr_packet_fifo_routing.sv */
// Packet byte FIFOs and receive channel routing of the on-chip HDLC controller.
// Assumes the host port, framer timing and HDLC bit engine all run on MCLK, so no input is resynchronised.
//
// Summary of operation
// - FIFO data registers hold one byte, MSB bit7
// - Transmit condition bits 7..3 unassigned, read zero
// - Transmit vacant flag high when FIFO empty
// - Transmit packed flag high when FIFO full; TX_FIFO_PACKED port follows one cycle late
// - Underflow set when FIFO dries mid-message
// - Underflow sends abort without software help
// - Underflow latches, cleared by reading condition
// - Source zero: Sa bits from control two
// - Source one: routing register fields choose input
// - Sa select: low bits enable Sa4..Sa8
// - Slot select: DS0 contents feed receiver
// - Mode zero: one slot by number field
// - Mode one: block map picks slots
// - Slot number field bits 4..0, MSB first
// - Suppress bits exclude matching slot bits
// - Last-byte mark precedes final byte, cleared after
// - Receive marks describe byte at head
// - Both FIFOs hold 64 bytes
`default_nettype none
`include "hfr_consts.svh"

module hfr_packet_fifo_routing #(
  parameter int DEPTH = `HFR_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST_N,
  // Parallel control port, one access per strobe.
  input wire logic [7:0] HOST_ADDR,
  input wire hfr_pkg::byte_t HOST_WDATA,
  input wire logic HOST_WR,
  input wire logic HOST_RD,
  output hfr_pkg::byte_t HOST_RDATA,
  output logic HOST_RVALID,
  // Framer receive timing and data.
  input wire logic RX_LINE_BIT,
  input wire logic RX_BIT_STB,
  input wire logic [4:0] RX_SLOT,
  input wire logic [2:0] RX_BIT_POS,
  input wire logic [4:0] RX_SA_HIT,
  input wire logic [4:0] RX_SA_CFG,
  input wire logic RX_BLOCK_HIT,
  // Routed bits towards the receive HDLC engine.
  output logic RX_HDLC_BIT,
  output logic RX_HDLC_STB,
  // Bytes from the receive HDLC engine.
  input wire hfr_pkg::byte_t RX_ENG_BYTE,
  input wire hfr_pkg::rx_mark_t RX_ENG_MARK,
  input wire logic RX_ENG_VALID,
  output logic RX_ENG_READY,
  // Receive condition towards the receive information register.
  output hfr_pkg::rx_mark_t RX_HEAD_MARK,
  output logic RX_FIFO_VACANT,
  // Bytes towards the transmit HDLC engine.
  input wire logic TX_ENG_REQ,
  output hfr_pkg::byte_t TX_ENG_BYTE,
  output logic TX_ENG_LAST,
  output logic TX_ENG_VALID,
  output logic TX_ABORT,
  // Last-byte mark held in the HDLC control register.
  input wire logic TX_LAST_MARK,
  output logic TX_LAST_MARK_CLR,
  // Transmit FIFO condition for the status logic.
  output logic TX_FIFO_VACANT,
  output logic TX_FIFO_PACKED
);
  import hfr_pkg::*;

  localparam int LW = $clog2(DEPTH + 1);
  localparam int RXW = 11; // Byte plus three marks.
  localparam int TXW = 9;  // Byte plus last-byte mark.

  // ---------------------------------------------------------------------------
  // FIFO instances.
  // ---------------------------------------------------------------------------
  hfr_fifo_if #(.WIDTH(RXW), .LW(LW)) rxq ();
  hfr_fifo_if #(.WIDTH(TXW), .LW(LW)) txq ();

  // Receive store, filled by the engine and drained by host reads.
  hfr_byte_fifo #(.WIDTH(RXW), .DEPTH(DEPTH)) u_rx_fifo (
    .clk(MCLK),
    .rst_n(RST_N),
    .q(rxq)
  );

  // Transmit store, filled by host writes and drained by the engine.
  hfr_byte_fifo #(.WIDTH(TXW), .DEPTH(DEPTH)) u_tx_fifo (
    .clk(MCLK),
    .rst_n(RST_N),
    .q(txq)
  );

  // ---------------------------------------------------------------------------
  // State registers.
  // ---------------------------------------------------------------------------
  byte_t route_reg, route_next;       // Receive routing select.
  byte_t suppress_reg, suppress_next; // Receive slot bit suppress.
  logic underflow_reg, underflow_next; // Latched transmit underflow.
  tx_msg_t msg_reg, msg_next;          // Transmit message in progress.
  byte_t rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic hbit_reg, hbit_next;
  logic hstb_reg, hstb_next;
  logic rx_ready_reg, rx_ready_next;
  rx_mark_t head_reg, head_next;
  logic rx_vacant_reg, rx_vacant_next;
  byte_t tbyte_reg, tbyte_next;
  logic tlast_reg, tlast_next;
  logic tvalid_reg, tvalid_next;
  logic abort_reg, abort_next;
  logic mark_clr_reg, mark_clr_next;
  logic tx_vacant_reg, tx_vacant_next;
  logic tx_packed_reg, tx_packed_next;

  // Decoded accesses.
  logic rd_rx_data, rd_tx_cond, wr_tx_data;
  logic tx_vacant_now, tx_packed_now; // Live FIFO condition.
  logic underflow_set;

  // True when an access strobe targets the given offset.
  function automatic logic hit(input logic stb, input logic [7:0] addr, input logic [7:0] ofs);
    hit = stb && (addr == ofs);
  endfunction : hit

  assign rd_rx_data = hit(HOST_RD, HOST_ADDR, `HFR_OFS_RX_PACKET_BYTE_FIFO);
  assign rd_tx_cond = hit(HOST_RD, HOST_ADDR, `HFR_OFS_TX_FIFO_CONDITION);
  assign wr_tx_data = hit(HOST_WR, HOST_ADDR, `HFR_OFS_TX_PACKET_BYTE_FIFO);
  assign tx_vacant_now = (txq.level == '0);
  assign tx_packed_now = (txq.level == LW'(DEPTH));

  // ---------------------------------------------------------------------------
  // FIFO hookup.
  // ---------------------------------------------------------------------------
  // The engine only pushes while the registered ready stands; a byte offered
  // without it is dropped, which the engine reports as its own overrun.
  assign rxq.in_data = {RX_ENG_MARK, RX_ENG_BYTE};
  assign rxq.in_valid = RX_ENG_VALID & rx_ready_reg;
  assign rxq.out_ready = rd_rx_data;
  // A write carries the last-byte mark with it, so the mark follows its byte.
  assign txq.in_data = {TX_LAST_MARK, HOST_WDATA};
  assign txq.in_valid = wr_tx_data;
  assign txq.out_ready = TX_ENG_REQ;

  // ---------------------------------------------------------------------------
  // Host port: register writes and read data.
  // ---------------------------------------------------------------------------
  // Reads answer one cycle after the strobe; an unmapped offset reads zero.
  always_comb begin
    route_next = route_reg;
    suppress_next = suppress_reg;
    rdata_next = `HFR_READ_IDLE;
    rvalid_next = HOST_RD;
    if (hit(HOST_WR, HOST_ADDR, `HFR_OFS_RX_ROUTING_SELECT)) begin
      route_next = HOST_WDATA;
    end
    if (hit(HOST_WR, HOST_ADDR, `HFR_OFS_RX_TIMESLOT_BIT_SUPPRESS)) begin
      suppress_next = HOST_WDATA;
    end
    if (HOST_RD) begin
      case (HOST_ADDR)
        `HFR_OFS_RX_PACKET_BYTE_FIFO: begin
          // An empty FIFO reads zero and nothing is removed.
          rdata_next = rxq.out_valid ? rxq.out_data[7:0] : `HFR_READ_IDLE;
        end
        `HFR_OFS_TX_FIFO_CONDITION: begin
          // Upper five bits are unassigned and read as zero.
          rdata_next = {5'h00, tx_vacant_now, tx_packed_now, underflow_reg};
        end
        `HFR_OFS_RX_ROUTING_SELECT: begin
          rdata_next = route_reg;
        end
        `HFR_OFS_RX_TIMESLOT_BIT_SUPPRESS: begin
          rdata_next = suppress_reg;
        end
        default: begin
          rdata_next = `HFR_READ_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit message tracking, underflow and abort.
  // ---------------------------------------------------------------------------
  // A request that finds the FIFO dry in the middle of a message is an
  // underflow: the flag latches and an abort pulse goes to the engine.
  always_comb begin
    msg_next = msg_reg;
    tbyte_next = tbyte_reg;
    tlast_next = 1'b0;
    tvalid_next = 1'b0;
    abort_next = 1'b0;
    mark_clr_next = 1'b0;
    underflow_set = 1'b0;
    if (TX_ENG_REQ) begin
      if (txq.out_valid) begin
        tbyte_next = txq.out_data[7:0];
        tlast_next = txq.out_data[8];
        tvalid_next = 1'b1;
        if (txq.out_data[8]) begin
          // The final byte has left; the control bit is released.
          msg_next = TX_IDLE;
          mark_clr_next = 1'b1;
        end else begin
          msg_next = TX_IN_MESSAGE;
        end
      end else begin
        case (msg_reg)
          TX_IN_MESSAGE: begin
            underflow_set = 1'b1;
            abort_next = 1'b1;
            msg_next = TX_IDLE;
          end
          TX_IDLE: begin
            msg_next = TX_IDLE;
          end
          default: begin
            msg_next = TX_IDLE;
          end
        endcase
      end
    end
    // A new underflow in the cycle of the clearing read is kept.
    underflow_next = underflow_set | (underflow_reg & ~rd_tx_cond);
    tx_vacant_next = LW'(txq.level + wr_tx_data) == LW'(TX_ENG_REQ & txq.out_valid);
    tx_packed_next = tx_packed_now;
  end

  // ---------------------------------------------------------------------------
  // Receive side: routed bit selection and head marks.
  // ---------------------------------------------------------------------------
  // Every framer bit strobe is passed on only when the bit belongs to the
  // chosen Sa positions or slots and, in the two slot modes, is not suppressed.
  always_comb begin
    logic take;
    take = 1'b0;
    if (!route_reg[`HFR_ROUTE_SOURCE_BIT]) begin
      take = |(RX_SA_HIT & RX_SA_CFG);
    end else if (!route_reg[`HFR_ROUTE_SA_OR_SLOT_BIT]) begin
      // Bit 4 enables Sa4 down to bit 0 for Sa8.
      take = |(RX_SA_HIT & route_reg[4:0]);
    end else if (route_reg[`HFR_ROUTE_MODE_BIT]) begin
      take = RX_BLOCK_HIT & ~suppress_reg[3'h7 - RX_BIT_POS];
    end else begin
      // Bit position 0 is the slot's first, most significant bit.
      take = (RX_SLOT == route_reg[`HFR_ROUTE_SLOT_MSB:`HFR_ROUTE_SLOT_LSB])
        & ~suppress_reg[3'h7 - RX_BIT_POS];
    end
    hstb_next = RX_BIT_STB & take;
    hbit_next = (RX_BIT_STB & take) ? RX_LINE_BIT : hbit_reg;
    // Keep one spare slot so a push in flight never meets a full store.
    rx_ready_next = (rxq.level < LW'(DEPTH - 1));
    head_next = rxq.out_valid ? rx_mark_t'(rxq.out_data[10:8]) : rx_mark_t'(3'h0);
    rx_vacant_next = ~rxq.out_valid;
  end

  // ---------------------------------------------------------------------------
  // Register all state and outputs.
  // ---------------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      route_reg <= `HFR_ROUTE_RESET;
      suppress_reg <= `HFR_SUPPRESS_RESET;
      underflow_reg <= 1'b0;
      msg_reg <= TX_IDLE;
      rdata_reg <= `HFR_READ_IDLE;
      rvalid_reg <= 1'b0;
      hbit_reg <= 1'b0;
      hstb_reg <= 1'b0;
      rx_ready_reg <= 1'b0;
      head_reg <= rx_mark_t'(3'h0);
      rx_vacant_reg <= 1'b1;
      tbyte_reg <= `HFR_READ_IDLE;
      tlast_reg <= 1'b0;
      tvalid_reg <= 1'b0;
      abort_reg <= 1'b0;
      mark_clr_reg <= 1'b0;
      tx_vacant_reg <= 1'b1;
      tx_packed_reg <= 1'b0;
    end else begin
      route_reg <= route_next;
      suppress_reg <= suppress_next;
      underflow_reg <= underflow_next;
      msg_reg <= msg_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      hbit_reg <= hbit_next;
      hstb_reg <= hstb_next;
      rx_ready_reg <= rx_ready_next;
      head_reg <= head_next;
      rx_vacant_reg <= rx_vacant_next;
      tbyte_reg <= tbyte_next;
      tlast_reg <= tlast_next;
      tvalid_reg <= tvalid_next;
      abort_reg <= abort_next;
      mark_clr_reg <= mark_clr_next;
      tx_vacant_reg <= tx_vacant_next;
      tx_packed_reg <= tx_packed_next;
    end
  end

  // Outputs come straight from the registers above.
  assign HOST_RDATA = rdata_reg;
  assign HOST_RVALID = rvalid_reg;
  assign RX_HDLC_BIT = hbit_reg;
  assign RX_HDLC_STB = hstb_reg;
  assign RX_ENG_READY = rx_ready_reg;
  assign RX_HEAD_MARK = head_reg;
  assign RX_FIFO_VACANT = rx_vacant_reg;
  assign TX_ENG_BYTE = tbyte_reg;
  assign TX_ENG_LAST = tlast_reg;
  assign TX_ENG_VALID = tvalid_reg;
  assign TX_ABORT = abort_reg;
  assign TX_LAST_MARK_CLR = mark_clr_reg;
  assign TX_FIFO_VACANT = tx_vacant_reg;
  assign TX_FIFO_PACKED = tx_packed_reg;
endmodule : hfr_packet_fifo_routing

`default_nettype wire

/* File: design/hfr_pkg.sv */
// Types shared by the packet FIFO and receive routing block.
// Assumes the constants header sits beside it on the include path.
`default_nettype none

package hfr_pkg;
  // One packet data byte, bit 7 the most significant.
  typedef logic [7:0] byte_t;
  // Receive byte marks: opening, closing and good-packet.
  typedef struct packed {
    logic first_byte_flag;
    logic final_byte_flag;
    logic good_packet_flag;
  } rx_mark_t;
  // Transmit message tracking state.
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_IN_MESSAGE = 1'b1
  } tx_msg_t;
endpackage : hfr_pkg

`default_nettype wire

/* File: test/hfr_props.sv */
// Checker for the packet FIFO and routing block, watching the top ports only.
// Assumes it is bound onto the top module; one clock, synchronous reset.
`default_nettype none

module hfr_props #(
  parameter int DEPTH = 64
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [7:0] HOST_ADDR,
  input wire logic HOST_RD,
  input wire hfr_pkg::byte_t HOST_RDATA,
  input wire logic HOST_RVALID,
  input wire logic RX_BIT_STB,
  input wire logic RX_HDLC_STB,
  input wire hfr_pkg::rx_mark_t RX_HEAD_MARK,
  input wire logic RX_FIFO_VACANT,
  input wire logic TX_ENG_REQ,
  input wire logic TX_ENG_VALID,
  input wire logic TX_ENG_LAST,
  input wire logic TX_ABORT,
  input wire logic TX_FIFO_VACANT,
  input wire logic TX_FIFO_PACKED
);
  timeunit 1ns / 1ps;
  // ---------------------------------------------------------------
  // Sequences and properties.
  // ---------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // A host read strobe taken at an edge.
  sequence rd_taken;
    HOST_RD;
  endsequence
  // A read of the transmit condition register.
  sequence cond_read;
    HOST_RD && HOST_ADDR == 8'hB6;
  endsequence
  // A byte or an abort must have been asked for by the engine.
  property eng_caused(logic ev);
    ev |-> $past(TX_ENG_REQ);
  endproperty

  rd_answer_a: assert property (rd_taken |=> HOST_RVALID) else $error("read not answered");
  read_quiet_a: assert property (!HOST_RD |=> !HOST_RVALID && HOST_RDATA == 8'h00)
    else $error("read data without a read");
  cond_reserved_a: assert property (cond_read |=> HOST_RDATA[7:3] == 5'b00000)
    else $error("unassigned condition bits set");
  flags_exclusive_a: assert property (!(TX_FIFO_VACANT && TX_FIFO_PACKED))
    else $error("empty and full together");
  stb_cause_a: assert property (!RX_BIT_STB |=> !RX_HDLC_STB) else $error("routed bit without strobe");
  byte_cause_a: assert property (eng_caused(TX_ENG_VALID)) else $error("byte not requested");
  abort_cause_a: assert property (eng_caused(TX_ABORT)) else $error("abort not requested");
  abort_pulse_a: assert property (TX_ABORT |-> !TX_ENG_VALID ##1 !TX_ABORT) else $error("abort too long");
  last_byte_a: assert property (TX_ENG_LAST |-> TX_ENG_VALID) else $error("last mark without byte");
  rx_marks_a: assert property (RX_FIFO_VACANT |-> RX_HEAD_MARK == 3'b000)
    else $error("marks on empty receive store");
endmodule : hfr_props

`default_nettype wire

/* File: test/host_port_model.sv */
// Host processor model for the parallel control port.
// Assumes strobes are sampled on the rising clock edge; one access per two cycles.
`default_nettype none

module host_port_model (
  // Clock.
  input wire logic clk,
  // Strobed access towards the device.
  output var logic [7:0] addr,
  output var hfr_pkg::byte_t wdata,
  output var logic wr,
  output var logic rd,
  // Answer from the device.
  input wire hfr_pkg::byte_t rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  import hfr_pkg::*;

  // Idle bus at time zero.
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One write strobe; released lines show the inverse so stale values never pass.
  task automatic write(input logic [7:0] a, input byte_t v);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    addr = ~a;
    wdata = ~v;
    @(posedge clk);
    #1;
  endtask : write

  // One read strobe; the answer is taken at the edge after the one that samples the strobe.
  task automatic read(input logic [7:0] a, output byte_t v, output logic ok);
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    addr = ~a;
    @(posedge clk);
    v = rdata;
    ok = rvalid;
    #1;
  endtask : read
endmodule : host_port_model

`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the packet FIFO and receive routing block.
// Assumes the host model and the checker are compiled before this file.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import hfr_pkg::*;
  // Small depth keeps fill and drain short.
  localparam int DEPTH = 8;
  logic MCLK, RST_N, HOST_WR, HOST_RD, HOST_RVALID, ok;
  logic [7:0] HOST_ADDR, r, s;
  byte_t HOST_WDATA, HOST_RDATA, RX_ENG_BYTE, TX_ENG_BYTE, d;
  logic RX_LINE_BIT, RX_BIT_STB, RX_BLOCK_HIT, RX_HDLC_BIT, RX_HDLC_STB, RX_ENG_VALID, RX_ENG_READY;
  logic [4:0] RX_SLOT, RX_SA_HIT, RX_SA_CFG;
  logic [2:0] RX_BIT_POS;
  rx_mark_t RX_ENG_MARK, RX_HEAD_MARK;
  logic RX_FIFO_VACANT, TX_ENG_REQ, TX_ENG_LAST, TX_ENG_VALID, TX_ABORT;
  logic TX_LAST_MARK, TX_LAST_MARK_CLR, TX_FIFO_VACANT, TX_FIFO_PACKED, e;
  logic [11:0] t;
  int num_errors, checks;
  byte_t q[$];
  rx_mark_t m[3] = '{3'b100, 3'b000, 3'b011};

  hfr_packet_fifo_routing #(.DEPTH(DEPTH)) i_hfr_packet_fifo_routing (
    .MCLK(MCLK), .RST_N(RST_N), .HOST_ADDR(HOST_ADDR), .HOST_WDATA(HOST_WDATA), .HOST_WR(HOST_WR),
    .HOST_RD(HOST_RD), .HOST_RDATA(HOST_RDATA), .HOST_RVALID(HOST_RVALID), .RX_LINE_BIT(RX_LINE_BIT),
    .RX_BIT_STB(RX_BIT_STB), .RX_SLOT(RX_SLOT), .RX_BIT_POS(RX_BIT_POS), .RX_SA_HIT(RX_SA_HIT),
    .RX_SA_CFG(RX_SA_CFG), .RX_BLOCK_HIT(RX_BLOCK_HIT), .RX_HDLC_BIT(RX_HDLC_BIT), .RX_HDLC_STB(RX_HDLC_STB),
    .RX_ENG_BYTE(RX_ENG_BYTE), .RX_ENG_MARK(RX_ENG_MARK), .RX_ENG_VALID(RX_ENG_VALID),
    .RX_ENG_READY(RX_ENG_READY), .RX_HEAD_MARK(RX_HEAD_MARK), .RX_FIFO_VACANT(RX_FIFO_VACANT),
    .TX_ENG_REQ(TX_ENG_REQ), .TX_ENG_BYTE(TX_ENG_BYTE), .TX_ENG_LAST(TX_ENG_LAST), .TX_ENG_VALID(TX_ENG_VALID),
    .TX_ABORT(TX_ABORT), .TX_LAST_MARK(TX_LAST_MARK), .TX_LAST_MARK_CLR(TX_LAST_MARK_CLR),
    .TX_FIFO_VACANT(TX_FIFO_VACANT), .TX_FIFO_PACKED(TX_FIFO_PACKED));

  host_port_model i_host_port_model (.clk(MCLK), .addr(HOST_ADDR), .wdata(HOST_WDATA), .wr(HOST_WR),
    .rd(HOST_RD), .rdata(HOST_RDATA), .rvalid(HOST_RVALID));

  // 125 MHz clock.
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  // Inputs change one nanosecond after the rising edge.
  task automatic tick;
    @(posedge MCLK);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic hrd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    i_host_port_model.read(a, d, ok);
    chk({nm, "_valid"}, {7'h00, ok}, 8'h01);
    chk(nm, d, exp);
  endtask : hrd

  // Engine asks for one byte; result is {clr, abort, last, valid, byte}.
  task automatic treq(output logic [11:0] res);
    TX_ENG_REQ = 1'b1;
    tick();
    TX_ENG_REQ = 1'b0;
    res = {TX_LAST_MARK_CLR, TX_ABORT, TX_ENG_LAST, TX_ENG_VALID, TX_ENG_BYTE};
    tick();
  endtask : treq

  // Expected routing decision for one framer bit.
  function automatic logic routed(logic [7:0] rr, ss, logic [4:0] sl, logic [2:0] p, logic [4:0] hit, cfg,
                                  logic blk);
    if (!rr[7]) return |(hit & cfg);
    if (!rr[6]) return |(hit & rr[4:0]);
    return (rr[5] ? blk : (sl == rr[4:0])) && !ss[3'd7 - p];
  endfunction : routed

  task automatic tally_and_finish;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // Watchdog: the whole run needs a few hundred cycles.
  initial begin
    repeat (20000) @(posedge MCLK);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    {RST_N, RX_LINE_BIT, RX_BIT_STB, RX_SLOT, RX_BIT_POS, RX_SA_HIT, RX_SA_CFG, RX_BLOCK_HIT} = '0;
    {RX_ENG_BYTE, RX_ENG_MARK, RX_ENG_VALID, TX_ENG_REQ, TX_LAST_MARK} = '0;
    void'($urandom(6));
    repeat (16) tick();
    RST_N = 1'b1;
    tick();
    chk("tx_vacant", {7'h00, TX_FIFO_VACANT}, 8'h01);
    hrd(8'hB8, 8'h00, "route");
    hrd(8'hB9, 8'h00, "suppress");
    hrd(8'hB6, 8'h04, "cond");
    hrd(8'hB5, 8'h00, "unmapped");
    $display("test reset done");
    // Fill one past full; the extra byte must be dropped.
    for (int i = 0; i <= DEPTH; i++) begin
      d = $urandom;
      if (i < DEPTH) q.push_back(d);
      i_host_port_model.write(8'hB7, d);
    end
    chk("tx_packed", {7'h00, TX_FIFO_PACKED}, 8'h01);
    hrd(8'hB6, 8'h02, "cond");
    for (int i = 0; i < DEPTH; i++) begin
      treq(t);
      chk("tx_flags", {5'h00, t[10:8]}, 8'h01);
      chk("tx_byte", t[7:0], q.pop_front());
    end
    chk("tx_vacant", {7'h00, TX_FIFO_VACANT}, 8'h01);
    treq(t);
    chk("tx_abort", {5'h00, t[10:8]}, 8'h04);
    hrd(8'hB6, 8'h05, "cond");
    hrd(8'hB6, 8'h04, "cond");
    $display("test tx underflow done");
    i_host_port_model.write(8'hB7, 8'hA5);
    TX_LAST_MARK = 1'b1;
    i_host_port_model.write(8'hB7, 8'h3C);
    TX_LAST_MARK = 1'b0;
    treq(t);
    chk("msg_first", {t[11:8], t[3:0]}, {4'b0001, 4'h5});
    treq(t);
    chk("msg_last", {t[11:8], t[3:0]}, {4'b1011, 4'hC});
    treq(t);
    chk("msg_idle", {5'h00, t[10:8]}, 8'h00);
    hrd(8'hB6, 8'h04, "cond");
    $display("test tx message done");
    // Receive engine pushes three marked bytes back to back.
    RX_ENG_VALID = 1'b1;
    for (int i = 0; i < 3; i++) begin
      RX_ENG_BYTE = $urandom;
      RX_ENG_MARK = m[i];
      q.push_back(RX_ENG_BYTE);
      chk("rx_ready", {7'h00, RX_ENG_READY}, 8'h01);
      tick();
    end
    RX_ENG_VALID = 1'b0;
    for (int i = 0; i < 3; i++) begin
      tick();
      tick();
      chk("head_mark", {5'h00, RX_HEAD_MARK}, {5'h00, m[i]});
      hrd(8'hB4, q.pop_front(), "rx_byte");
    end
    hrd(8'hB4, 8'h00, "rx_empty");
    chk("rx_vacant", {7'h00, RX_FIFO_VACANT}, 8'h01);
    $display("test rx done");
    // Every source, select and mode combination, random bits under each.
    for (int k = 0; k < 8; k++) begin
      r = $urandom;
      r[7:5] = k[2:0];
      s = $urandom;
      i_host_port_model.write(8'hB8, r);
      i_host_port_model.write(8'hB9, s);
      hrd(8'hB8, r, "route");
      hrd(8'hB9, s, "suppress");
      repeat (30) begin
        {RX_LINE_BIT, RX_BIT_POS, RX_SA_CFG, RX_BLOCK_HIT} = $urandom;
        RX_SLOT = ($urandom % 2) ? r[4:0] : 5'($urandom);
        RX_SA_HIT = 5'(6'h01 << ($urandom % 6));
        e = routed(r, s, RX_SLOT, RX_BIT_POS, RX_SA_HIT, RX_SA_CFG, RX_BLOCK_HIT);
        RX_BIT_STB = 1'b1;
        tick();
        RX_BIT_STB = 1'b0;
        chk("routed_stb", {7'h00, RX_HDLC_STB}, {7'h00, e});
        if (e) chk("routed_bit", {7'h00, RX_HDLC_BIT}, {7'h00, RX_LINE_BIT});
        tick();
      end
    end
    $display("test routing done");
    tally_and_finish();
  end
endmodule : testbench

bind hfr_packet_fifo_routing hfr_props #(.DEPTH(DEPTH)) i_hfr_props (.MCLK(MCLK), .RST_N(RST_N),
  .HOST_ADDR(HOST_ADDR), .HOST_RD(HOST_RD), .HOST_RDATA(HOST_RDATA), .HOST_RVALID(HOST_RVALID),
  .RX_BIT_STB(RX_BIT_STB), .RX_HDLC_STB(RX_HDLC_STB), .RX_HEAD_MARK(RX_HEAD_MARK),
  .RX_FIFO_VACANT(RX_FIFO_VACANT), .TX_ENG_REQ(TX_ENG_REQ), .TX_ENG_VALID(TX_ENG_VALID),
  .TX_ENG_LAST(TX_ENG_LAST), .TX_ABORT(TX_ABORT), .TX_FIFO_VACANT(TX_FIFO_VACANT),
  .TX_FIFO_PACKED(TX_FIFO_PACKED));

`default_nettype wire
